// >>> shared/sysctl_defines.svh
// constants for the system control port block: addresses, bit positions, reset values
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// ============================================================
// i/o address map, compare value and mask per on-board range
`define IO_ADDR_W          10
`define DEC_PIC_BASE       10'h020
`define DEC_PIC_MASK       10'h3f8
`define DEC_TIMER_BASE     10'h040
`define DEC_TIMER_MASK     10'h3f8
`define DEC_PPI_BASE       10'h060
`define DEC_PPI_MASK       10'h3f8
`define DEC_CTL_BASE       10'h0a0
`define DEC_CTL_MASK       10'h3f8
`define DEC_SOUND_BASE     10'h0c0
`define DEC_SOUND_MASK     10'h3f8
`define DEC_DISK_BASE      10'h0f0
`define DEC_DISK_MASK      10'h3f0
`define DEC_JOY_BASE       10'h200
`define DEC_JOY_MASK       10'h3f8
`define DEC_SERIAL_BASE    10'h2f8
`define DEC_SERIAL_MASK    10'h3f8
`define DEC_VIDEO_BASE     10'h3d0
`define DEC_VIDEO_MASK     10'h3f0
`define DEC_MODEM_BASE     10'h3f8
`define DEC_MODEM_MASK     10'h3f8

// ============================================================
// peripheral interface port index (low two address bits)
`define PPI_IDX_A          2'h0
`define PPI_IDX_B          2'h1
`define PPI_IDX_C          2'h2

// ============================================================
// control port bit positions
`define CTL_NMI_EN_BIT     7
`define CTL_IR_EN_BIT      6
`define CTL_T1_SEL_BIT     5
`define CTL_HRQ_INH_BIT    4

// ============================================================
// output port b bit positions
`define PB_T2_GATE_BIT     0
`define PB_SPK_GATE_BIT    1
`define PB_TEXT_BIT        2
`define PB_MOTOR_OFF_BIT   3
`define PB_BEEP_DIS_BIT    4
`define PB_SND_LO_BIT      5
`define PB_SND_HI_BIT      6

// ============================================================
// reset values
`define PA_RESET           8'h00
`define PB_RESET           8'h08
`define DATA_IDLE          8'h00

// ============================================================
// timing figures software must program into the external timer
`define IR_MOD_FREQ_HZ     40000
`define T1_FIXED_CLK_HZ    1192500

`endif

// >>> shared/sysctl_pkg.sv
// types shared by the system control port block
package sysctl_pkg;

  // ============================================================
  // one select per on-board i/o range
  typedef struct packed {
    logic pic;
    logic timer;
    logic ppi;
    logic ctl;
    logic sound;
    logic diskette;
    logic joystick;
    logic serial;
    logic video;
    logic modem;
  } dev_sel_t;

  // ============================================================
  // sound source codes on the steering outputs
  typedef enum logic [1:0] {
    SND_TIMER2   = 2'b00,
    SND_CASSETTE = 2'b01,
    SND_CHANNEL  = 2'b10,
    SND_COMPLEX  = 2'b11
  } snd_src_t;

  // ============================================================
  // state of the keyboard latch module
  typedef struct packed {
    logic kbd_data_q;
    logic latched;
  } kbd_state_t;

  // ============================================================
  // state of the top block
  typedef struct packed {
    logic       rd_n_q;
    logic       wr_n_q;
    logic       nmi_enable_bit;
    logic       infrared_loopback_enable;
    logic       timer1_clock_select;
    logic [7:0] keystroke_scratch;
    logic [7:0] control_out;
    logic [7:0] rdata;
    logic       rdata_oe;
    logic       nmi;
    logic       ir_emitter;
    logic       timer1_clk;
    logic       speaker;
    logic       timer2_sound;
    logic       motor_on;
  } ctl_state_t;

endpackage

// >>> design/io_range_decoder.sv
// address decoder for the on-board i/o ranges
`timescale 1ns/1ps
`default_nettype none

module io_range_decoder
  import sysctl_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              io_cycle,
  output dev_sel_t               sel,
  output logic                   any_hit
);

`include "sysctl_defines.svh"

  // ============================================================
  // match helper
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] base,
                               input logic [ADDR_W-1:0] mask);
    hit = ((a & mask) == base);
  endfunction

  // ============================================================
  // each range compares only the bits it decodes
  always_comb begin
    sel.pic      = io_cycle & hit(addr, `DEC_PIC_BASE,    `DEC_PIC_MASK);
    sel.timer    = io_cycle & hit(addr, `DEC_TIMER_BASE,  `DEC_TIMER_MASK);
    sel.ppi      = io_cycle & hit(addr, `DEC_PPI_BASE,    `DEC_PPI_MASK);
    sel.ctl      = io_cycle & hit(addr, `DEC_CTL_BASE,    `DEC_CTL_MASK);
    sel.sound    = io_cycle & hit(addr, `DEC_SOUND_BASE,  `DEC_SOUND_MASK);
    sel.diskette = io_cycle & hit(addr, `DEC_DISK_BASE,   `DEC_DISK_MASK);
    sel.joystick = io_cycle & hit(addr, `DEC_JOY_BASE,    `DEC_JOY_MASK);
    sel.serial   = io_cycle & hit(addr, `DEC_SERIAL_BASE, `DEC_SERIAL_MASK);
    sel.video    = io_cycle & hit(addr, `DEC_VIDEO_BASE,  `DEC_VIDEO_MASK);
    sel.modem    = io_cycle & hit(addr, `DEC_MODEM_BASE,  `DEC_MODEM_MASK);
    // anything else stays free for expansion adapters
    any_hit      = |sel;
  end

endmodule

`default_nettype wire

// >>> design/keyboard_nmi_latch.sv
// keyboard start-bit latch that raises the nmi
`timescale 1ns/1ps
`default_nettype none

module keyboard_nmi_latch
  import sysctl_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic kbd_data,
  input  wire logic clear,
  output logic      latched
);

  kbd_state_t state_ff;
  kbd_state_t nxt_state;

  // ============================================================
  // set on the first rising edge only; set beats a same-cycle clear
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.kbd_data_q = kbd_data;
    if (kbd_data && !state_ff.kbd_data_q) begin
      nxt_state.latched = 1'b1;
    end else if (clear) begin
      nxt_state.latched = 1'b0;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign latched = state_ff.latched;

endmodule

`default_nettype wire

// >>> design/system_control_ports.sv
// system control ports: i/o decode, nmi control port and peripheral port bits
//
// What this block does
// - decode only own i/o ranges, leave rest
// - nmi enable cleared at power-on
// - control bit 7 gates keyboard nmi
// - control bit 6 feeds timer2 to infrared
// - control bit 5 picks timer1 clock source
// - latch sets on first keyboard rising edge
// - control port read clears latch, no data
// - no new nmi until latch cleared
// - latch state readable on input bit 0
// - first output port is plain scratch storage
// - port b bit 0 gates timer2
// - port b bit 1 ands timer2 output
// - port b bit 2 steers video data
// - motor runs only when bits 3,4 low
// - port b bit 4 silences beeper, motor
// - port b bits 6,5 select sound source
// - cassette input loops timer2 when motor off
// - input bit 5 shows live timer2 output
// - keyboard data from cable else infrared
// - four active-low presence inputs read zero when present
`timescale 1ns/1ps
`default_nettype none

module system_control_ports
  import sysctl_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  // processor i/o bus
  input  wire logic [ADDR_W-1:0] IO_ADDR,
  input  wire logic              IO_M,
  input  wire logic              IOR_N,
  input  wire logic              IOW_N,
  input  wire logic [7:0]        DATA_IN,
  output logic [7:0]             DATA_OUT,
  output logic                   DATA_OE,
  output dev_sel_t               DEV_SEL,
  output logic                   BOARD_DECODE,
  output logic                   NMI,
  // timer hookup
  input  wire logic              TIMER0_OUT,
  input  wire logic              TIMER2_OUT,
  input  wire logic              FIXED_T1_CLK,
  output logic                   TIMER1_CLK,
  output logic                   TIMER2_GATE,
  // sound, video and cassette
  output logic                   SPEAKER,
  output logic                   TIMER2_SOUND,
  output snd_src_t               AUDIO_SOURCE_SEL,
  output logic                   VIDEO_TEXT_STEER,
  output logic                   CASSETTE_MOTOR_ON,
  input  wire logic              CASSETTE_SHAPED_IN,
  // keyboard and infrared
  input  wire logic              KBD_CABLE_DATA,
  input  wire logic              IR_RX_DATA,
  output logic                   IR_EMITTER,
  // presence straps, active low
  input  wire logic              KBD_CABLE_PRESENT_N,
  input  wire logic              MODEM_PRESENT_N,
  input  wire logic              DISKETTE_PRESENT_N,
  input  wire logic              EXPANSION_PRESENT_N
);

`include "sysctl_defines.svh"

  ctl_state_t state_ff;
  ctl_state_t nxt_state;

  dev_sel_t   sel;
  logic       any_hit;
  logic       rd_start;
  logic       wr_start;
  logic       rd_active;
  logic       latch_clear;
  logic       kbd_latched;
  logic       keyboard_serial_in;
  logic       cassette_data_in;
  logic [7:0] status_in;

  // ============================================================
  // address decode of the on-board ranges
  io_range_decoder #(
    .ADDR_W   (ADDR_W)
  ) u_decode (
    .addr     (IO_ADDR),
    .io_cycle (IO_M),
    .sel      (sel),
    .any_hit  (any_hit)
  );

  // ============================================================
  // strobe edges: writes and the latch clear are taken once, in the first cycle the strobe is low
  assign rd_active   = IO_M & ~IOR_N;
  assign rd_start    = rd_active & state_ff.rd_n_q;
  assign wr_start    = IO_M & ~IOW_N & state_ff.wr_n_q;
  // any read in the control range clears the latch, whatever low bits
  assign latch_clear = rd_start & sel.ctl;

  // ============================================================
  // keyboard source and its start-bit latch
  // a cable plugged in overrides the infrared receiver
  assign keyboard_serial_in = KBD_CABLE_PRESENT_N ? IR_RX_DATA
                                                  : KBD_CABLE_DATA;

  keyboard_nmi_latch u_kbd_latch (
    .clk      (CLK),
    .nrst     (NRST),
    .kbd_data (keyboard_serial_in),
    .clear    (latch_clear),
    .latched  (kbd_latched)
  );

  // ============================================================
  // cassette input: tape data while the motor runs, timer2 wrap otherwise
  assign cassette_data_in = state_ff.motor_on ? CASSETTE_SHAPED_IN
                                              : TIMER2_OUT;

  // ============================================================
  // input port c assembly, straps pass through unchanged
  always_comb begin
    status_in    = `DATA_IDLE;
    status_in[0] = kbd_latched;
    status_in[1] = MODEM_PRESENT_N;
    status_in[2] = DISKETTE_PRESENT_N;
    status_in[3] = EXPANSION_PRESENT_N;
    status_in[4] = cassette_data_in;
    status_in[5] = TIMER2_OUT;
    status_in[6] = keyboard_serial_in;
    status_in[7] = KBD_CABLE_PRESENT_N;
  end

  // ============================================================
  // next state: writes, read data, derived outputs
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.rd_n_q = ~rd_active;
    nxt_state.wr_n_q = ~(IO_M & ~IOW_N);

    // control port write; the hold-inhibit bit and bits 3..0 are dropped,
    // each bus master keeps its own copy of bit 4
    if (wr_start && sel.ctl) begin
      nxt_state.nmi_enable_bit           = DATA_IN[`CTL_NMI_EN_BIT];
      nxt_state.infrared_loopback_enable = DATA_IN[`CTL_IR_EN_BIT];
      nxt_state.timer1_clock_select      = DATA_IN[`CTL_T1_SEL_BIT];
    end

    // peripheral port writes; port c is input only, control word ignored
    if (wr_start && sel.ppi) begin
      unique case (IO_ADDR[1:0])
        `PPI_IDX_A: begin
          nxt_state.keystroke_scratch = DATA_IN;
        end
        `PPI_IDX_B: begin
          nxt_state.control_out = DATA_IN;
        end
        default: begin
          nxt_state.control_out = state_ff.control_out;
        end
      endcase
    end

    // read data: only the peripheral ports answer; the control range
    // read is a dummy and leaves the data bus undriven
    nxt_state.rdata_oe = rd_active & sel.ppi & (IO_ADDR[1:0] != 2'h3);
    nxt_state.rdata    = state_ff.rdata;
    if (rd_active && sel.ppi) begin
      unique case (IO_ADDR[1:0])
        `PPI_IDX_A: begin
          nxt_state.rdata = state_ff.keystroke_scratch;
        end
        `PPI_IDX_B: begin
          nxt_state.rdata = state_ff.control_out;
        end
        `PPI_IDX_C: begin
          nxt_state.rdata = status_in;
        end
        default: begin
          nxt_state.rdata = `DATA_IDLE;
        end
      endcase
    end

    // nmi follows the latch while enabled; a held latch gives no new edge
    nxt_state.nmi = kbd_latched & state_ff.nmi_enable_bit;

    // infrared diagnostic drive of timer2 into the emitter
    nxt_state.ir_emitter = state_ff.infrared_loopback_enable & TIMER2_OUT;

    // timer1 clock: fixed clock or cascade from timer0
    nxt_state.timer1_clk = state_ff.timer1_clock_select ? TIMER0_OUT
                                                        : FIXED_T1_CLK;

    // timer2 sound gated by the data bit
    nxt_state.timer2_sound = TIMER2_OUT & state_ff.control_out[`PB_SPK_GATE_BIT];

    // internal beeper silenced by the disable bit
    nxt_state.speaker = nxt_state.timer2_sound
                      & ~state_ff.control_out[`PB_BEEP_DIS_BIT];

    // motor runs only with both motor-off and relay-disable low
    nxt_state.motor_on = ~state_ff.control_out[`PB_MOTOR_OFF_BIT]
                       & ~state_ff.control_out[`PB_BEEP_DIS_BIT];
  end

  // ============================================================
  // state register; nmi enable clear out of reset keeps the nmi masked
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff                          <= '0;
      state_ff.rd_n_q                   <= 1'b1;
      state_ff.wr_n_q                   <= 1'b1;
      state_ff.nmi_enable_bit           <= 1'b0;
      state_ff.keystroke_scratch        <= `PA_RESET;
      state_ff.control_out              <= `PB_RESET;
      state_ff.rdata                    <= `DATA_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // outputs; decode selects are combinational chip selects
  assign DEV_SEL           = sel;
  assign BOARD_DECODE      = any_hit;
  assign DATA_OUT          = state_ff.rdata;
  assign DATA_OE           = state_ff.rdata_oe;
  assign NMI               = state_ff.nmi;
  assign IR_EMITTER        = state_ff.ir_emitter;
  assign TIMER1_CLK        = state_ff.timer1_clk;
  assign TIMER2_GATE       = state_ff.control_out[`PB_T2_GATE_BIT];
  assign TIMER2_SOUND      = state_ff.timer2_sound;
  assign SPEAKER           = state_ff.speaker;
  assign AUDIO_SOURCE_SEL  = snd_src_t'({state_ff.control_out[`PB_SND_HI_BIT],
                                         state_ff.control_out[`PB_SND_LO_BIT]});
  assign VIDEO_TEXT_STEER  = state_ff.control_out[`PB_TEXT_BIT];
  assign CASSETTE_MOTOR_ON = state_ff.motor_on;

endmodule

`default_nettype wire

// >>> tb/sysctl_host_model.sv
// processor-side bus model that runs i/o read and write cycles
`timescale 1ns/1ps
`default_nettype none

module sysctl_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe,
  output logic      [9:0] io_addr,
  output logic            io_m,
  output logic            ior_n,
  output logic            iow_n,
  output logic      [7:0] wdata
);
  logic hold_inhibit;
  logic hold_request_n;

  // an attached master with work pending asks for the bus on every clock,
  // synchronous to clk, but never while its own inhibit copy is set
  always @(posedge clk) begin
    hold_request_n <= hold_inhibit;
  end

  // idle bus: no strobe, no cycle
  initial begin
    io_addr = 10'h000;
    io_m = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    wdata = 8'h00;
    hold_inhibit = 1'b0;
  end

  // ====================
  // bus cycles
  // one low edge per write, then a high edge so the next access is legal
  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    io_m    <= 1'b1;
    io_addr <= a;
    wdata   <= d;
    iow_n   <= 1'b0;
    if (a[9:3] == 7'h14) hold_inhibit = d[4];
    @(posedge clk);
    iow_n   <= 1'b1;
    wdata   <= ~d; // released lines show junk, never the old byte
    @(posedge clk);
  endtask

  // answer is taken at the second low edge, before that edge's updates land
  task automatic io_read(input logic [9:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    io_m    <= 1'b1;
    io_addr <= a;
    ior_n   <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    d  = rdata;
    oe = rdata_oe;
    ior_n   <= 1'b1;
    @(posedge clk);
  endtask

  // address phase only, for looking at the combinational decode
  task automatic drive_addr(input logic [9:0] a);
    @(posedge clk);
    io_m    <= 1'b1;
    io_addr <= a;
    #1;
  endtask
endmodule

`default_nettype wire

// >>> tb/system_control_ports_monitor.sv
// assertion checker for the system control port block
`timescale 1ns/1ps
`default_nettype none

module system_control_ports_monitor
  import sysctl_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic              CLK,
  input wire logic              NRST,
  input wire logic [ADDR_W-1:0] IO_ADDR,
  input wire logic              IO_M,
  input wire logic              IOR_N,
  input wire logic              IOW_N,
  input wire logic              DATA_OE,
  input wire dev_sel_t          DEV_SEL,
  input wire logic              BOARD_DECODE,
  input wire logic              NMI,
  input wire logic              TIMER0_OUT,
  input wire logic              TIMER2_OUT,
  input wire logic              FIXED_T1_CLK,
  input wire logic              TIMER1_CLK,
  input wire logic              SPEAKER,
  input wire logic              TIMER2_SOUND,
  input wire logic              IR_EMITTER,
  input wire logic              KBD_CABLE_DATA,
  input wire logic              IR_RX_DATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic ctl_hit;

  // ====================
  // checks
  // control port range a0-a7
  assign ctl_hit = IO_M && (IO_ADDR[9:3] == 7'h14);

  a_unmapped_left_free: assert property (IO_M && IO_ADDR[9:4] == 6'h10 |-> !BOARD_DECODE)
    else $error("unmapped address decoded on board");
  a_ctl_range_decode: assert property (ctl_hit |-> DEV_SEL.ctl && BOARD_DECODE)
    else $error("control range not decoded");
  a_ctl_read_quiet: assert property (ctl_hit && $fell(IOR_N) |=> !DATA_OE [*2])
    else $error("control port read drove data");
  // data low now and one cycle back on both sources, so no set can win over the clear
  a_read_clears_nmi: assert property (ctl_hit && $fell(IOR_N) && !KBD_CABLE_DATA && !IR_RX_DATA
    && !$past(KBD_CABLE_DATA) && !$past(IR_RX_DATA) |-> ##2 !NMI)
    else $error("nmi still high after control read");
  a_nmi_holds: assert property (NMI && IOR_N && IOW_N && $past(IOR_N) && $past(IOW_N)
    |=> NMI)
    else $error("nmi dropped without a clearing access");
  a_ppi_read_answer: assert property (IO_M && IO_ADDR == 10'h062 && $fell(IOR_N) |=> DATA_OE)
    else $error("port c read not answered");
  a_oe_release: assert property ($rose(IOR_N) |=> !DATA_OE)
    else $error("data enable held after strobe");
  a_speaker_in_sound: assert property (SPEAKER |-> TIMER2_SOUND)
    else $error("speaker active without gated timer sound");
  a_timer2_and_gate: assert property (!TIMER2_OUT |=> !TIMER2_SOUND && !IR_EMITTER)
    else $error("timer2 low but gated outputs high");
  a_t1_clk_follows: assert property (TIMER0_OUT == FIXED_T1_CLK
    |=> TIMER1_CLK == $past(TIMER0_OUT))
    else $error("timer1 clock matches neither source");
  a_reset_quiet: assert property ($rose(NRST) |-> !NMI && !DATA_OE)
    else $error("nmi or data enable active out of reset");

  c_nmi_raised: cover property ($rose(NMI));
  c_ctl_read: cover property (ctl_hit && $fell(IOR_N));
  c_t1_cascade: cover property (TIMER1_CLK && !FIXED_T1_CLK);
endmodule

bind system_control_ports system_control_ports_monitor #(.ADDR_W(ADDR_W)) monitor_inst (
  .CLK(CLK), .NRST(NRST), .IO_ADDR(IO_ADDR), .IO_M(IO_M), .IOR_N(IOR_N), .IOW_N(IOW_N),
  .DATA_OE(DATA_OE), .DEV_SEL(DEV_SEL), .BOARD_DECODE(BOARD_DECODE), .NMI(NMI),
  .TIMER0_OUT(TIMER0_OUT), .TIMER2_OUT(TIMER2_OUT), .FIXED_T1_CLK(FIXED_T1_CLK),
  .TIMER1_CLK(TIMER1_CLK), .SPEAKER(SPEAKER), .TIMER2_SOUND(TIMER2_SOUND),
  .IR_EMITTER(IR_EMITTER), .KBD_CABLE_DATA(KBD_CABLE_DATA), .IR_RX_DATA(IR_RX_DATA)
);

`default_nettype wire

// >>> tb/system_control_ports_bench.sv
// self-checking bench for the system control port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module system_control_ports_bench;
  import sysctl_pkg::*;
  logic       CLK, NRST, IO_M, IOR_N, IOW_N, DATA_OE, BOARD_DECODE, NMI, oe;
  logic       TIMER0_OUT, TIMER2_OUT, FIXED_T1_CLK, TIMER1_CLK, TIMER2_GATE, SPEAKER;
  logic       TIMER2_SOUND, VIDEO_TEXT_STEER, CASSETTE_MOTOR_ON, CASSETTE_SHAPED_IN;
  logic       KBD_CABLE_DATA, IR_RX_DATA, IR_EMITTER, KBD_CABLE_PRESENT_N;
  logic       MODEM_PRESENT_N, DISKETTE_PRESENT_N, EXPANSION_PRESENT_N;
  logic [9:0] IO_ADDR;
  logic [7:0] DATA_IN, DATA_OUT, rd;
  dev_sel_t   DEV_SEL;
  snd_src_t   AUDIO_SOURCE_SEL;
  int         fails, num_checks, cyc;

  system_control_ports system_control_ports_inst (
    .CLK(CLK), .NRST(NRST), .IO_ADDR(IO_ADDR), .IO_M(IO_M), .IOR_N(IOR_N),
    .IOW_N(IOW_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .DEV_SEL(DEV_SEL), .BOARD_DECODE(BOARD_DECODE), .NMI(NMI), .TIMER0_OUT(TIMER0_OUT),
    .TIMER2_OUT(TIMER2_OUT), .FIXED_T1_CLK(FIXED_T1_CLK), .TIMER1_CLK(TIMER1_CLK),
    .TIMER2_GATE(TIMER2_GATE), .SPEAKER(SPEAKER), .TIMER2_SOUND(TIMER2_SOUND),
    .AUDIO_SOURCE_SEL(AUDIO_SOURCE_SEL), .VIDEO_TEXT_STEER(VIDEO_TEXT_STEER),
    .CASSETTE_MOTOR_ON(CASSETTE_MOTOR_ON), .CASSETTE_SHAPED_IN(CASSETTE_SHAPED_IN),
    .KBD_CABLE_DATA(KBD_CABLE_DATA), .IR_RX_DATA(IR_RX_DATA), .IR_EMITTER(IR_EMITTER),
    .KBD_CABLE_PRESENT_N(KBD_CABLE_PRESENT_N), .MODEM_PRESENT_N(MODEM_PRESENT_N),
    .DISKETTE_PRESENT_N(DISKETTE_PRESENT_N), .EXPANSION_PRESENT_N(EXPANSION_PRESENT_N)
  );

  sysctl_host_model host_model_inst (
    .clk(CLK), .rdata(DATA_OUT), .rdata_oe(DATA_OE), .io_addr(IO_ADDR), .io_m(IO_M),
    .ior_n(IOR_N), .iow_n(IOW_N), .wdata(DATA_IN)
  );

  // ====================
  // clock, timeout, verdict
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // a hang counts as a mismatch; the whole run needs well under 1000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out;
    end
  end

  task automatic close_out;
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // ====================
  // scenarios
  task automatic t_reset;
    `CHK(NMI, 1'b0)
    `CHK(AUDIO_SOURCE_SEL, SND_TIMER2)
    host_model_inst.io_write(10'h060, 8'ha5);
    host_model_inst.io_read(10'h060, rd, oe);
    `CHK(rd, 8'ha5)
  endtask

  // every sound code, then beeper-off and motor-off corners with timer2 high
  task automatic t_port_b;
    @(posedge CLK);
    TIMER2_OUT <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_model_inst.io_write(10'h061, 8'h03 | (8'(i) << 5));
      wait_n(2);
      `CHK(AUDIO_SOURCE_SEL, snd_src_t'(i))
      `CHK({TIMER2_GATE, SPEAKER, CASSETTE_MOTOR_ON}, 3'b111)
    end
    host_model_inst.io_write(10'h061, 8'h16);
    wait_n(2);
    `CHK({TIMER2_GATE, VIDEO_TEXT_STEER}, 2'h1)
    `CHK({SPEAKER, TIMER2_SOUND, CASSETTE_MOTOR_ON}, 3'h2)
    host_model_inst.io_write(10'h061, 8'h08);
    wait_n(2);
    `CHK({SPEAKER, TIMER2_SOUND, VIDEO_TEXT_STEER}, 3'b000)
    `CHK(CASSETTE_MOTOR_ON, 1'b0)
  endtask

  // port c: straps, timer2 live, cassette loop-back with motor off then tape with motor on
  task automatic t_status;
    host_model_inst.io_read(10'h062, rd, oe);
    `CHK(rd, 8'h3a)
    host_model_inst.io_write(10'h061, 8'h00);
    host_model_inst.io_read(10'h062, rd, oe);
    `CHK(rd, 8'h2a)
    @(posedge CLK);
    TIMER2_OUT <= 1'b0;
    CASSETTE_SHAPED_IN <= 1'b1;
    host_model_inst.io_read(10'h062, rd, oe);
    `CHK(rd, 8'h1a)
  endtask

  task automatic t_nmi;
    host_model_inst.io_write(10'h0a0, 8'h80);
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b1;
    wait_n(4);
    `CHK(NMI, 1'b1)
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b0;
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b1;
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b0;
    host_model_inst.io_read(10'h062, rd, oe);
    `CHK(rd[0], 1'b1)
    host_model_inst.io_read(10'h0a3, rd, oe);
    `CHK(oe, 1'b0)
    wait_n(3);
    `CHK(NMI, 1'b0)
    // masked: a keystroke sets the latch but raises no nmi
    host_model_inst.io_write(10'h0a0, 8'h00);
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b1;
    wait_n(4);
    `CHK(NMI, 1'b0)
    host_model_inst.io_read(10'h062, rd, oe);
    `CHK(rd[0], 1'b1)
    // cable unplugged: the infrared receiver becomes the source
    @(posedge CLK);
    KBD_CABLE_DATA <= 1'b0;
    KBD_CABLE_PRESENT_N <= 1'b1;
    host_model_inst.io_read(10'h0a0, rd, oe);
    host_model_inst.io_write(10'h0a0, 8'h80);
    @(posedge CLK);
    IR_RX_DATA <= 1'b1;
    wait_n(4);
    `CHK(NMI, 1'b1)
    @(posedge CLK);
    IR_RX_DATA <= 1'b0;
    host_model_inst.io_read(10'h0a0, rd, oe);
    wait_n(3);
    `CHK(NMI, 1'b0)
  endtask

  task automatic t_ctl_bits;
    @(posedge CLK);
    TIMER0_OUT <= 1'b1;
    TIMER2_OUT <= 1'b1;
    host_model_inst.io_write(10'h0a0, 8'h7f);
    wait_n(2);
    `CHK({TIMER1_CLK, IR_EMITTER, NMI}, 3'b110)
    `CHK(host_model_inst.hold_request_n, 1'b1)
    host_model_inst.io_write(10'h0a7, 8'h1f);
    wait_n(2);
    `CHK({TIMER1_CLK, IR_EMITTER}, 2'b00)
    // inhibit bit cleared again: the attached master may ask for the bus
    host_model_inst.io_write(10'h0a0, 8'h00);
    `CHK(host_model_inst.hold_request_n, 1'b0)
  endtask

  task automatic t_decode;
    logic [9:0] hit [10];
    logic [9:0] miss [5];
    hit = '{10'h027, 10'h047, 10'h066, 10'h0a5, 10'h0c7, 10'h0ff, 10'h207, 10'h2fc,
            10'h3d9, 10'h3f8};
    miss = '{10'h028, 10'h0b0, 10'h100, 10'h2f0, 10'h208};
    for (int i = 0; i < 10; i++) begin
      host_model_inst.drive_addr(hit[i]);
      `CHK(BOARD_DECODE, 1'b1)
    end
    for (int i = 0; i < 5; i++) begin
      host_model_inst.drive_addr(miss[i]);
      `CHK(BOARD_DECODE, 1'b0)
    end
    host_model_inst.io_read(10'h100, rd, oe);
    `CHK(oe, 1'b0)
  endtask

  // ====================
  // main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    cyc = 0;
    NRST = 1'b0;
    TIMER0_OUT = 1'b0;
    TIMER2_OUT = 1'b0;
    FIXED_T1_CLK = 1'b0;
    CASSETTE_SHAPED_IN = 1'b0;
    KBD_CABLE_DATA = 1'b0;
    IR_RX_DATA = 1'b0;
    KBD_CABLE_PRESENT_N = 1'b0;
    MODEM_PRESENT_N = 1'b1;
    DISKETTE_PRESENT_N = 1'b0;
    EXPANSION_PRESENT_N = 1'b1;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    wait_n(1);
    t_reset;
    t_port_b;
    t_status;
    t_nmi;
    t_ctl_bits;
    t_decode;
    close_out;
  end
endmodule

`default_nettype wire
